// *** verilog/cprc_params.svh ***
`ifndef CPRC_PARAMS_SVH
`define CPRC_PARAMS_SVH
// Register byte offsets
`define CPRC_ADR_CTRL 8'h00
`define CPRC_ADR_STAT 8'h04
`define CPRC_ADR_IRQ_STAT 8'h08
`define CPRC_ADR_IRQ_CLR 8'h0C
`define CPRC_ADR_IRQ_EN 8'h10
// Control fields
`define CPRC_CTRL_DIV_LO 0
`define CPRC_CTRL_LPDE 2
`define CPRC_CTRL_SWB 3
`define CPRC_CTRL_STOP 4
`define CPRC_CTRL_SRC_LO 5
`define CPRC_CTRL_XSWB 7
`define CPRC_CTRL_LBDE 8
`define CPRC_CTRL_LBIE 9
`define CPRC_CTRL_BOD_STOP 10
`define CPRC_CTRL_WUT_EN 11
`define CPRC_CTRL_EXT_EN 12
`define CPRC_CTRL_RST 13'h0000
// Interrupt status bits
`define CPRC_IRQ_LB 0
`define CPRC_IRQ_WARM 1
`define CPRC_IRQ_WAKE 2
`define CPRC_IRQ_POR 3
// Timing
`define CPRC_WARM_COUNT 17'h10000
`define CPRC_PMM_DIV 9'h100
`define CPRC_RESET_VECTOR 16'h8000
`endif

// *** verilog/cprc_pkg.sv ***
package cprc_pkg;
  typedef enum logic [1:0] {
    cprc_src_ext,
    cprc_src_xtal,
    cprc_src_rc,
    cprc_src_ring
  } cprc_src_type;
  typedef enum {
    cprc_run,
    cprc_stop,
    cprc_warm
  } cprc_state_type;
endpackage

// *** verilog/cprc_top.sv ***
`timescale 1ns/100ps
`include "cprc_params.svh"
// How it works
// - Clock from external, crystal, RC or ring.
// - Crystal restart waits 65536 oscillations.
// - Ring clocks warm-up; optional crystal switchback.
// - Low battery sets flag and/or interrupt.
// - Divide select gives 1,2,4,8 oscillator cycles.
// - Enable with divide 00 gives divide-by-256.
// - Enabled interrupt with switchback exits divide-by-256.
// - Stop bit halts crystal and system clock.
// - Stop ends on external interrupt, wake timer, reset.
// - After stop, run on ring during warm-up.
// - Reset halts execution, oscillators keep running.
// - Power-on and brownout reset; brownout stop-disable.
// - Power-on reset flags, picks ring, starts warm-up.
module cprc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic xtal_osc_i,
  input wire logic ext_clk_i,
  input wire logic rc_osc_i,
  input wire logic ring_osc_i,
  input wire logic vdd_above_reset_threshold_i,
  input wire logic batt_below_low_battery_threshold_i,
  input wire logic ext_irq_i,
  input wire logic wake_timer_expired_i,
  input wire logic reset_pin_n_i,
  input wire logic core_irq_i,
  output logic system_clock_cycle_o,
  output logic core_run_o,
  output logic core_reset_o,
  output logic [15:0] reset_vector_o,
  output logic xtal_enable_o,
  output logic divide_by_256_mode_o,
  output logic irq_o
);
  // Two-flop synchronisers for all pins and oscillator levels
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] sync3;
  always_ff @(posedge clk_i)
  begin
    sync1 <= {xtal_osc_i, ext_clk_i, rc_osc_i, ring_osc_i, vdd_above_reset_threshold_i,
      batt_below_low_battery_threshold_i, ext_irq_i, wake_timer_expired_i, reset_pin_n_i};
    sync2 <= sync1;
    sync3 <= sync2;
  end
  logic xtal_s, ext_s, rc_s, ring_s, vdd_ok, batt_low, ext_irq, wake_exp, pin_rst_n;
  assign {xtal_s, ext_s, rc_s, ring_s, vdd_ok, batt_low, ext_irq, wake_exp, pin_rst_n} = sync2;
  logic [3:0] osc_rise;
  assign osc_rise = sync2[8:5] & ~sync3[8:5];

  // Registers
  logic [12:0] ctrl, next_ctrl;
  logic [3:0] irq_stat, next_irq_stat;
  logic [3:0] irq_en, next_irq_en;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic low_battery_flag, next_low_battery_flag;
  logic power_on_flag, next_power_on_flag;
  cprc_pkg::cprc_state_type state, next_state;
  cprc_pkg::cprc_src_type act_src, next_act_src;
  logic [16:0] warm_cnt, next_warm_cnt;
  logic [7:0] div_cnt, next_div_cnt;
  logic sys_clk, next_sys_clk;
  logic vdd_ok_q, next_vdd_ok_q;

  function automatic logic [7:0] div_limit(input logic [1:0] sel, input logic divide_by_256_mode);
    logic [7:0] r;
    r = 8'h00;
    if (divide_by_256_mode)
      r = 8'(`CPRC_PMM_DIV - 1);
    else
      r = 8'((1 << sel) - 1);
    return r;
  endfunction

  logic wr, rd, halted, divide_by_256_mode, warm_done, por_event, bod_en, brown;
  logic [1:0] div_sel;
  cprc_pkg::cprc_src_type sel_src;
  assign div_sel = ctrl[`CPRC_CTRL_DIV_LO +: 2];
  assign sel_src = cprc_pkg::cprc_src_type'(ctrl[`CPRC_CTRL_SRC_LO +: 2]);
  assign divide_by_256_mode = ctrl[`CPRC_CTRL_LPDE] && div_sel == 2'h0;
  assign wr = cyc_i && stb_i && we_i && !ack;
  assign rd = cyc_i && stb_i && !we_i && !ack;
  assign warm_done = warm_cnt == `CPRC_WARM_COUNT;
  // Brownout may be ignored during stop when configured
  assign bod_en = !(state == cprc_pkg::cprc_stop && ctrl[`CPRC_CTRL_BOD_STOP]);
  assign brown = !vdd_ok && bod_en;
  assign por_event = vdd_ok && !vdd_ok_q;
  assign halted = state == cprc_pkg::cprc_stop;

  always_comb
  begin
    logic src_edge;
    logic [3:0] ev;
    next_ctrl = ctrl;
    next_irq_stat = irq_stat;
    next_irq_en = irq_en;
    next_ack = cyc_i && stb_i && !ack;
    next_rdat = 32'h00000000;
    next_low_battery_flag = low_battery_flag;
    next_power_on_flag = power_on_flag;
    next_state = state;
    next_act_src = act_src;
    next_warm_cnt = warm_cnt;
    next_div_cnt = div_cnt;
    // System clock is a one-cycle pulse, low unless a period just ended
    next_sys_clk = 1'b0;
    next_vdd_ok_q = vdd_ok;
    ev = 4'h0;
    src_edge = 1'b0;
    // Bus reads and writes
    if (rd)
    begin
      case (adr_i)
        `CPRC_ADR_CTRL: next_rdat = {19'h00000, ctrl};
        `CPRC_ADR_STAT: next_rdat = {24'h000000, power_on_flag, low_battery_flag,
          warm_done, state == cprc_pkg::cprc_warm, halted, divide_by_256_mode, 2'(act_src)};
        `CPRC_ADR_IRQ_STAT: next_rdat = {28'h0000000, irq_stat};
        `CPRC_ADR_IRQ_EN: next_rdat = {28'h0000000, irq_en};
        default: next_rdat = 32'h00000000;
      endcase
    end
    if (wr && adr_i == `CPRC_ADR_CTRL)
    begin
      if (sel_i[0])
        next_ctrl[7:0] = dat_i[7:0];
      if (sel_i[1])
        next_ctrl[12:8] = dat_i[12:8];
    end
    if (wr && adr_i == `CPRC_ADR_IRQ_EN && sel_i[0])
      next_irq_en = dat_i[3:0];
    if (wr && adr_i == `CPRC_ADR_IRQ_CLR && sel_i[0])
      next_irq_stat = irq_stat & ~dat_i[3:0];
    // Low battery detection
    if (ctrl[`CPRC_CTRL_LBDE] && batt_low)
    begin
      next_low_battery_flag = 1'b1;
      ev[`CPRC_IRQ_LB] = ctrl[`CPRC_CTRL_LBIE];
    end
    // Switchback out of divide-by-256 on a core or external interrupt request
    if (divide_by_256_mode && ctrl[`CPRC_CTRL_SWB] && (core_irq_i || ext_irq))
      next_ctrl[`CPRC_CTRL_LPDE] = 1'b0;
    case (state)
      cprc_pkg::cprc_run:
      begin
        if (next_ctrl[`CPRC_CTRL_STOP])
          next_state = cprc_pkg::cprc_stop;
        else
          next_act_src = sel_src;
        if (sel_src == cprc_pkg::cprc_src_xtal && act_src != cprc_pkg::cprc_src_xtal)
        begin
          // Crystal selected anew must warm up first
          next_state = cprc_pkg::cprc_warm;
          next_act_src = cprc_pkg::cprc_src_ring;
          next_warm_cnt = 17'h00000;
        end
      end
      cprc_pkg::cprc_stop:
      begin
        if ((ext_irq && ctrl[`CPRC_CTRL_EXT_EN]) || (wake_exp && ctrl[`CPRC_CTRL_WUT_EN]))
        begin
          next_ctrl[`CPRC_CTRL_STOP] = 1'b0;
          next_state = cprc_pkg::cprc_warm;
          next_act_src = cprc_pkg::cprc_src_ring;
          next_warm_cnt = 17'h00000;
          ev[`CPRC_IRQ_WAKE] = 1'b1;
        end
      end
      cprc_pkg::cprc_warm:
      begin
        if (!warm_done && osc_rise[3])
          next_warm_cnt = warm_cnt + 17'h00001;
        if (next_ctrl[`CPRC_CTRL_STOP])
          next_state = cprc_pkg::cprc_stop;
        else if (warm_done)
        begin
          next_state = cprc_pkg::cprc_run;
          ev[`CPRC_IRQ_WARM] = 1'b1;
          if (ctrl[`CPRC_CTRL_XSWB])
            next_act_src = cprc_pkg::cprc_src_xtal;
          else
          begin
            next_act_src = cprc_pkg::cprc_src_ring;
            next_ctrl[`CPRC_CTRL_SRC_LO +: 2] = 2'(cprc_pkg::cprc_src_ring);
          end
        end
      end
      default: next_state = cprc_pkg::cprc_run;
    endcase
    // Divider counts rising edges of the active oscillator
    case (act_src)
      cprc_pkg::cprc_src_ext: src_edge = osc_rise[2];
      cprc_pkg::cprc_src_xtal: src_edge = osc_rise[3];
      cprc_pkg::cprc_src_rc: src_edge = osc_rise[1];
      default: src_edge = osc_rise[0];
    endcase
    // Ratio and source changes take effect at once, so one period may end short
    if (halted)
    begin
      next_sys_clk = 1'b0;
      next_div_cnt = 8'h00;
    end
    else if (src_edge)
    begin
      if (div_cnt >= div_limit(div_sel, divide_by_256_mode))
      begin
        next_div_cnt = 8'h00;
        next_sys_clk = 1'b1;
      end
      else
      begin
        next_div_cnt = div_cnt + 8'h01;
        next_sys_clk = 1'b0;
      end
    end
    next_irq_stat = next_irq_stat | ev;
    // Power-on or brownout resets the block and flags it
    if (por_event || brown || !pin_rst_n)
    begin
      next_ctrl = `CPRC_CTRL_RST;
      next_irq_en = 4'h0;
      next_state = cprc_pkg::cprc_warm;
      next_act_src = cprc_pkg::cprc_src_ring;
      next_warm_cnt = 17'h00000;
      next_low_battery_flag = 1'b0;
      if (por_event || brown)
      begin
        next_power_on_flag = 1'b1;
        next_irq_stat = irq_stat | 4'h8;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= `CPRC_CTRL_RST;
      irq_stat <= 4'h0;
      irq_en <= 4'h0;
      ack <= 1'b0;
      rdat <= 32'h00000000;
      low_battery_flag <= 1'b0;
      power_on_flag <= 1'b1;
      state <= cprc_pkg::cprc_warm;
      act_src <= cprc_pkg::cprc_src_ring;
      warm_cnt <= 17'h00000;
      div_cnt <= 8'h00;
      sys_clk <= 1'b0;
      vdd_ok_q <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      ack <= next_ack;
      rdat <= next_rdat;
      low_battery_flag <= next_low_battery_flag;
      power_on_flag <= next_power_on_flag;
      state <= next_state;
      act_src <= next_act_src;
      warm_cnt <= next_warm_cnt;
      div_cnt <= next_div_cnt;
      sys_clk <= next_sys_clk;
      vdd_ok_q <= next_vdd_ok_q;
    end
  end

  // Core reset holds execution only; oscillators are never gated by it
  logic core_reset;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      core_reset <= 1'b1;
    else
      core_reset <= por_event || brown || !pin_rst_n;
  end

  assign dat_o = rdat;
  assign ack_o = ack;
  assign system_clock_cycle_o = sys_clk;
  assign core_run_o = !halted && !core_reset;
  assign core_reset_o = core_reset;
  assign reset_vector_o = `CPRC_RESET_VECTOR;
  assign xtal_enable_o = !halted && (state == cprc_pkg::cprc_warm || act_src == cprc_pkg::cprc_src_xtal);
  assign divide_by_256_mode_o = divide_by_256_mode;
  assign irq_o = |(irq_stat & irq_en);
endmodule

// *** verif/cprc_sva.sv ***
`timescale 1ns/100ps
module cprc_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic vdd_above_reset_threshold_i,
  input wire logic reset_pin_n_i,
  input wire logic system_clock_cycle_o,
  input wire logic core_run_o,
  input wire logic core_reset_o,
  input wire logic [15:0] reset_vector_o,
  input wire logic xtal_enable_o,
  input wire logic divide_by_256_mode_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  a_vector_fixed: assert property (reset_vector_o == 16'h8000)
    else $error("bad vector");
  a_reset_holds: assert property (disable iff (1'b0) rst_i |=> core_reset_o)
    else $error("reset not held");
  a_run_halted: assert property (core_reset_o |-> !core_run_o)
    else $error("run in reset");
  a_pin_reset: assert property (!reset_pin_n_i [*5] |-> core_reset_o)
    else $error("pin ignored");
  a_sys_pulse: assert property (system_clock_cycle_o |=> !system_clock_cycle_o)
    else $error("clock runt");
  // Middle cycle of a stop run, so registered outputs may lag entry
  a_stop_quiet: assert property (
    (!core_run_o && !core_reset_o) [*3] |->
    !$past(xtal_enable_o) && !$past(system_clock_cycle_o))
    else $error("clock in stop");
  a_release_drops: assert property (
    $fell(rst_i) && vdd_above_reset_threshold_i && reset_pin_n_i |-> ##[1:5] !core_reset_o)
    else $error("reset stuck");
  c_div256: cover property (divide_by_256_mode_o);
  c_wake: cover property ($rose(core_run_o));
  c_bus: cover property (ack_o);
endmodule
bind cprc_top cprc_sva i_cprc_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .vdd_above_reset_threshold_i, .reset_pin_n_i, .system_clock_cycle_o, .core_run_o,
  .core_reset_o, .reset_vector_o, .xtal_enable_o, .divide_by_256_mode_o);

// *** verif/cprc_osc_model.sv ***
`timescale 1ns/100ps
module cprc_osc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic xtal_enable_i,
  output logic xtal_osc_o,
  output logic ext_clk_o,
  output logic ring_osc_o,
  output logic [31:0] xtal_edges_o
);
  logic [2:0] div;
  initial
  begin
    div = 3'h0;
    xtal_osc_o = 1'b0;
    ext_clk_o = 1'b0;
    xtal_edges_o = 32'h0;
  end
  assign ring_osc_o = div[2];
  // A disabled crystal stands still; its edge count restarts with it
  always @(posedge clk_i)
  begin
    div <= div + 3'h1;
    ext_clk_o <= ~ext_clk_o;
    xtal_osc_o <= xtal_enable_i & ~xtal_osc_o;
    if (rst_i || !xtal_enable_i)
      xtal_edges_o <= 32'h0;
    else if (!xtal_osc_o)
      xtal_edges_o <= xtal_edges_o + 32'h1;
  end
endmodule

// *** verif/cprc_top_test.sv ***
`timescale 1ns/100ps
module cprc_top_test;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd, edges;
  logic [3:0] sel_i = 4'hF;
  logic vdd = 1, batt = 0, eirq = 0, wake = 0, pin_n = 1, cirq = 0;
  logic xo, eo, go, sc, run, crst, xen, d256, ack_o, irq_o;
  logic [15:0] vec;
  int n_fail = 0, comparisons = 0, k, t;
  initial forever #4 clk_i = ~clk_i;
  cprc_osc_model i_cprc_osc_model (.clk_i, .rst_i, .xtal_enable_i(xen), .xtal_osc_o(xo),
    .ext_clk_o(eo), .ring_osc_o(go), .xtal_edges_o(edges));
  cprc_top i_cprc_top (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
    .stb_i, .ack_o, .xtal_osc_i(xo), .ext_clk_i(eo), .rc_osc_i(1'b0), .ring_osc_i(go),
    .vdd_above_reset_threshold_i(vdd), .batt_below_low_battery_threshold_i(batt),
    .ext_irq_i(eirq), .wake_timer_expired_i(wake), .reset_pin_n_i(pin_n),
    .core_irq_i(cirq), .system_clock_cycle_o(sc), .core_run_o(run), .core_reset_o(crst),
    .reset_vector_o(vec), .xtal_enable_o(xen), .divide_by_256_mode_o(d256), .irq_o);
  task automatic close_out;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic await(ref logic s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && s !== v; i++)
      @(posedge clk_i);
    if (i == lim)
    begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    await(ack_o, 1'b1, 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    check(32'({crst, vec}), 32'h8000);
    bus(1'b0, 8'h04, 32'h0);
    check(rd, 32'h93);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h10, 32'h2);
    await(irq_o, 1'b1, 140000);
    check(32'(edges >= 32'h10000 && edges < 32'h1000A), 32'h1);
    bus(1'b1, 8'h0C, 32'h2);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h8);
    bus(1'b1, 8'h0C, 32'h8);
    // Two pulses are skipped so a ratio change settles before measuring
    for (k = 0; k < 5; k++)
    begin
      bus(1'b1, 8'h00, 32'(k < 4 ? k : 4));
      await(sc, 1'b1, 600);
      @(posedge clk_i);
      await(sc, 1'b1, 600);
      @(posedge clk_i);
      for (t = 1; sc !== 1'b1 && t < 600; t++)
        @(posedge clk_i);
      check(t, k < 4 ? 2 << k : 512);
    end
    check(32'(d256), 32'h1);
    bus(1'b1, 8'h00, 32'hC);
    cirq <= 1'b1;
    await(d256, 1'b0, 600);
    cirq <= 1'b0;
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h00, 32'h300);
    batt <= 1'b1;
    await(irq_o, 1'b1, 40);
    batt <= 1'b0;
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    check(32'(rd[6] && !irq_o), 32'h1);
    for (k = 0; k < 3; k++)
    begin
      bus(1'b1, 8'h00, {19'h0, k == 1, k == 0, 11'h010});
      await(run, 1'b0, 20);
      cirq <= 1'b1;
      repeat (8) @(posedge clk_i);
      check(32'({run, xen, sc}), 32'h0);
      wake <= k == 0;
      eirq <= k == 1;
      pin_n <= k != 2;
      cirq <= 1'b0;
      repeat (8) @(posedge clk_i);
      wake <= 1'b0;
      eirq <= 1'b0;
      pin_n <= 1'b1;
      await(run, 1'b1, 40);
      bus(1'b0, 8'h04, 32'h0);
      check(32'({xen, rd[4], rd[1:0]}), 32'hF);
    end
    close_out();
  end
endmodule
